/* File: dri_map.svh */
// Register offsets, field positions, reset values and init codes
`ifndef DRI_MAP_SVH
`define DRI_MAP_SVH
`define DRI_OFS_ID 8'h00
`define DRI_OFS_STAT 8'h04
`define DRI_OFS_CFG 8'h08
`define DRI_OFS_RFC 8'h0C
`define DRI_OFS_TIM1 8'h10
`define DRI_OFS_TIM2 8'h14
`define DRI_OFS_CTL 8'h18
`define DRI_CFG_PS_LSB 0
`define DRI_CFG_IB_LSB 4
`define DRI_CFG_CL_LSB 9
`define DRI_CFG_NM_BIT 14
`define DRI_CFG_TU_BIT 15
`define DRI_CFG_DRV_BIT 18
`define DRI_CFG_BU_BIT 23
`define DRI_CFG_DRV_MASK 32'h0004_0000
`define DRI_TIM1_WR_LSB 16
`define DRI_RFC_RATE_LSB 0
`define DRI_CTL_RL_LSB 0
`define DRI_CTL_X8_BIT 8
`define DRI_CFG_RST 32'h0000_0832
`define DRI_RFC_RST 32'h0000_079E
`define DRI_TIM1_RST 32'h0003_0000
`define DRI_TIM2_RST 32'h0000_0000
`define DRI_CTL_RST 32'h0000_0005
`define DRI_MR_BL8 3'h3
`define DRI_EMR1_RTT 13'h0004
`define DRI_A10_PRE 13'h0400
`define DRI_BA_MR 3'h0
`define DRI_BA_EMR1 3'h1
`define DRI_BA_EMR2 3'h2
`define DRI_BA_EMR3 3'h3
`define DRI_PAGE_BASE 12'h100
`endif

/* File: dri_pkg.sv */
// Types shared by the reinit controller and its init sequencer
package dri_pkg;
  typedef enum logic [1:0] {
    DRI_NOP = 2'h0,
    DRI_PRE_ALL = 2'h1,
    DRI_LOAD_MODE = 2'h2,
    DRI_REFRESH = 2'h3
  } dri_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_DRAIN = 3'h2,
    ST_INIT = 3'h4
  } dri_ctl_t;
  typedef enum logic [8:0] {
    SQ_IDLE = 9'h001,
    SQ_PRE1 = 9'h002,
    SQ_EMR2 = 9'h004,
    SQ_EMR3 = 9'h008,
    SQ_EMR1 = 9'h010,
    SQ_MRS = 9'h020,
    SQ_PRE2 = 9'h040,
    SQ_REF = 9'h080,
    SQ_LAST = 9'h100
  } dri_seq_t;
  typedef enum logic [1:0] {
    TOPO_32_X16 = 2'h0,
    TOPO_16_X16 = 2'h1,
    TOPO_16_X8 = 2'h2,
    TOPO_BAD = 2'h3
  } dri_topo_t;
endpackage

/* File: dri_init_seq.sv */
// Memory initialisation command sequencer, one step per link clock edge
`timescale 1ns/10ps
`include "dri_map.svh"
module dri_init_seq import dri_pkg::*; (
  input logic core_clk,
  input logic reset,
  input logic start,
  input logic link_edge,
  input logic [12:0] mrs_word,
  input logic [12:0] emr1_word,
  output logic cke,
  output dri_cmd_t cmd,
  output logic [2:0] ba,
  output logic [12:0] addr,
  output logic busy,
  output logic done
);
  dri_seq_t state_reg;
  dri_seq_t state_next;
  dri_cmd_t cmd_next;
  logic [2:0] ba_next;
  logic [12:0] addr_next;

  always_comb begin
    state_next = state_reg;
    cmd_next = cmd;
    ba_next = ba;
    addr_next = addr;
    if (link_edge) begin
      case (state_reg)
        SQ_IDLE: begin
          cmd_next = DRI_NOP;
        end
        SQ_PRE1, SQ_PRE2: begin
          cmd_next = DRI_PRE_ALL;
          addr_next = `DRI_A10_PRE;
          state_next = (state_reg == SQ_PRE1) ? SQ_EMR2 : SQ_REF;
        end
        SQ_EMR2, SQ_EMR3: begin
          cmd_next = DRI_LOAD_MODE;
          ba_next = (state_reg == SQ_EMR2) ? `DRI_BA_EMR2 : `DRI_BA_EMR3;
          addr_next = 13'h0000;
          state_next = (state_reg == SQ_EMR2) ? SQ_EMR3 : SQ_EMR1;
        end
        SQ_EMR1: begin
          cmd_next = DRI_LOAD_MODE;
          ba_next = `DRI_BA_EMR1;
          addr_next = emr1_word;
          state_next = SQ_MRS;
        end
        SQ_MRS: begin
          cmd_next = DRI_LOAD_MODE;
          ba_next = `DRI_BA_MR;
          addr_next = mrs_word;
          state_next = SQ_PRE2;
        end
        SQ_REF: begin
          cmd_next = DRI_REFRESH;
          state_next = SQ_LAST;
        end
        SQ_LAST: begin
          cmd_next = DRI_NOP;
          state_next = SQ_IDLE;
        end
        default: begin
          state_next = SQ_IDLE;
        end
      endcase
    end
    if (start && state_reg == SQ_IDLE) begin
      state_next = SQ_PRE1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= SQ_IDLE;
      cmd <= DRI_NOP;
      ba <= 3'h0;
      addr <= 13'h0000;
      cke <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd <= cmd_next;
      ba <= ba_next;
      addr <= addr_next;
      cke <= cke | start;
      busy <= (state_next != SQ_IDLE);
      done <= link_edge && (state_reg == SQ_LAST);
    end
  end

  sequence s_last_step;
    state_reg == SQ_LAST && link_edge;
  endsequence
  a_refresh_then_idle: assert property (
    @(posedge core_clk) disable iff (reset)
    s_last_step |=> done && cmd == DRI_NOP && state_reg == SQ_IDLE)
    else $error("init did not end idle after one refresh");
endmodule

/* File: dri_ctrl.sv */
// Configuration registers, drain and reinit control of the DDR2 controller
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "dri_map.svh"
// Summary of operation
// - Low-lane config write starts memory init
// - Register-triggered init keeps queued FIFO contents
// - Finish accepted reads and writes before init
// - Unlock bit one opens, zero locks timings
// - Width select zero means 32-bit bus
// - CAS latency field encodes latency directly
// - Bank count field 3h means eight banks
// - Page size field 2h means 1024 words
// - Controller raises no interrupts at all
// - Pure bus slave, no DMA events
// - Keeps running through debug halts
// - Three supported bus and part topologies
// - Init ends with one refresh, then idle
// - Mode register: burst eight, CAS, write recovery
// - Reset starts init, FIFO contents lost
module dri_ctrl import dri_pkg::*; #(
  parameter logic [31:0] MODULE_ID = 32'h00A5_0001 // Arbitrary value
) (
  input logic core_clk,
  input logic reset,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input logic mem_clk_in,
  input logic rw_outstanding,
  output logic cmd_hold,
  output logic fifo_flush,
  output logic mem_cke,
  output dri_cmd_t mem_cmd,
  output logic [2:0] mem_ba,
  output logic [12:0] mem_addr,
  output logic cfg_bus32,
  output logic [2:0] cfg_cas_lat,
  output logic [3:0] cfg_banks,
  output logic [11:0] cfg_page_words,
  output logic [2:0] cfg_read_lat,
  output logic [15:0] cfg_refresh_rate,
  output dri_topo_t topology
);
  function automatic logic [3:0] lanes(input logic [2:0] sz,
                                       input logic [1:0] a);
    case (sz)
      3'h0: lanes = 4'h1 << a;
      3'h1: lanes = a[1] ? 4'hC : 4'h3;
      default: lanes = 4'hF;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] ln);
    for (int i = 0; i < 4; i++) begin
      if (ln[i]) begin
        old[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = old;
  endfunction

  logic [31:0] cfg_reg, rfc_reg, tim1_reg, tim2_reg, ctl_reg;
  logic wr_ph_reg, rd_ph_reg;
  logic [7:0] wa_reg, ra_reg;
  logic [3:0] wl_reg;
  logic lk_s1_reg, lk_s2_reg, lk_s3_reg;
  dri_ctl_t state_reg, state_next;
  logic start_reg, start_next, pend_reg;
  logic seq_busy, seq_done;

  wire addr_take = hsel && hready && htrans[1];
  wire wr_apply = wr_ph_reg && hready;
  wire cfg_wr = wr_apply && wa_reg == `DRI_OFS_CFG;
  wire trig = cfg_wr && (|wl_reg[1:0]);
  wire tim_open = cfg_reg[`DRI_CFG_TU_BIT];
  wire [31:0] cfg_m = merge(cfg_reg, hwdata, wl_reg);
  // Drive strength only moves in the write after boot unlock was set
  wire drv_ok = cfg_reg[`DRI_CFG_BU_BIT];
  wire [31:0] cfg_w = (cfg_m & ~`DRI_CFG_DRV_MASK) |
                      ((drv_ok ? cfg_m : cfg_reg) & `DRI_CFG_DRV_MASK);
  wire link_edge = lk_s2_reg && !lk_s3_reg;
  wire [2:0] cl_fld = cfg_reg[`DRI_CFG_CL_LSB +: 3];
  wire nm_fld = cfg_reg[`DRI_CFG_NM_BIT];
  wire x8_fld = ctl_reg[`DRI_CTL_X8_BIT];
  wire [12:0] mrs_word = {1'b0, tim1_reg[`DRI_TIM1_WR_LSB +: 3], 2'b00,
                          cl_fld, 1'b0, `DRI_MR_BL8};
  wire [12:0] emr1_word = `DRI_EMR1_RTT |
                          {11'h000, cfg_reg[`DRI_CFG_DRV_BIT], 1'b0};
  wire [31:0] stat_word = {27'h0000000, topology, cmd_hold,
                           state_reg == ST_DRAIN, seq_busy};
  wire [31:0] rd_mux =
    (ra_reg == `DRI_OFS_ID) ? MODULE_ID :
    (ra_reg == `DRI_OFS_STAT) ? stat_word :
    (ra_reg == `DRI_OFS_CFG) ? cfg_reg :
    (ra_reg == `DRI_OFS_RFC) ? rfc_reg :
    (ra_reg == `DRI_OFS_TIM1) ? tim1_reg :
    (ra_reg == `DRI_OFS_TIM2) ? tim2_reg :
    (ra_reg == `DRI_OFS_CTL) ? ctl_reg : 32'h0000_0000;
  wire dri_topo_t topo_w = !nm_fld ? (x8_fld ? TOPO_BAD : TOPO_32_X16) :
                           (x8_fld ? TOPO_16_X8 : TOPO_16_X16);

  // Bus slave: writes are zero wait, reads insert one wait state so the
  // read mux sees any write that finished in the same cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ph_reg <= 1'b0;
      rd_ph_reg <= 1'b0;
      wa_reg <= 8'h00;
      ra_reg <= 8'h00;
      wl_reg <= 4'h0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_ph_reg <= addr_take && hwrite;
      rd_ph_reg <= addr_take && !hwrite;
      if (addr_take) begin
        wa_reg <= {haddr[7:2], 2'b00};
        ra_reg <= {haddr[7:2], 2'b00};
        wl_reg <= lanes(hsize, haddr[1:0]);
      end
      hreadyout <= !(addr_take && !hwrite);
      if (rd_ph_reg) begin
        hrdata <= rd_mux;
      end
    end
  end

  // No interrupt or DMA event outputs; every answer is OKAY
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_reg <= `DRI_CFG_RST;
      rfc_reg <= `DRI_RFC_RST;
      tim1_reg <= `DRI_TIM1_RST;
      tim2_reg <= `DRI_TIM2_RST;
      ctl_reg <= `DRI_CTL_RST;
    end else if (wr_apply) begin
      if (cfg_wr) begin
        cfg_reg <= cfg_w;
      end
      if (wa_reg == `DRI_OFS_RFC) begin
        rfc_reg <= merge(rfc_reg, hwdata, wl_reg);
      end
      if (wa_reg == `DRI_OFS_TIM1 && tim_open) begin
        tim1_reg <= merge(tim1_reg, hwdata, wl_reg);
      end
      if (wa_reg == `DRI_OFS_TIM2 && tim_open) begin
        tim2_reg <= merge(tim2_reg, hwdata, wl_reg);
      end
      if (wa_reg == `DRI_OFS_CTL) begin
        ctl_reg <= merge(ctl_reg, hwdata, wl_reg);
      end
    end
  end

  // Memory clock is foreign: two flops, then an edge finder
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // Reset high: a clock already high at release is not a rising edge
      lk_s1_reg <= 1'b1;
      lk_s2_reg <= 1'b1;
      lk_s3_reg <= 1'b1;
    end else begin
      lk_s1_reg <= mem_clk_in;
      lk_s2_reg <= lk_s1_reg;
      lk_s3_reg <= lk_s2_reg;
    end
  end

  // No halt input: the sequence runs whatever the debugger does
  always_comb begin
    state_next = state_reg;
    start_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (trig || pend_reg) begin
          state_next = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (!rw_outstanding) begin
          state_next = ST_INIT;
          start_next = 1'b1;
        end
      end
      ST_INIT: begin
        if (seq_done) begin
          state_next = pend_reg ? ST_DRAIN : ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // A trigger during init is remembered; it wins over the clear
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_INIT;
      start_reg <= 1'b1;
      fifo_flush <= 1'b1;
      cmd_hold <= 1'b1;
      pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      start_reg <= start_next;
      fifo_flush <= 1'b0;
      cmd_hold <= (state_next != ST_IDLE);
      pend_reg <= (trig && state_reg == ST_INIT) ||
                  (pend_reg && state_reg == ST_INIT && !seq_done);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_bus32 <= 1'b0;
      cfg_cas_lat <= 3'h0;
      cfg_banks <= 4'h0;
      cfg_page_words <= 12'h000;
      cfg_read_lat <= 3'h0;
      cfg_refresh_rate <= 16'h0000;
      topology <= TOPO_32_X16;
    end else begin
      cfg_bus32 <= !nm_fld;
      cfg_cas_lat <= cl_fld;
      cfg_banks <= 4'h1 << cfg_reg[`DRI_CFG_IB_LSB +: 2];
      cfg_page_words <= `DRI_PAGE_BASE << cfg_reg[`DRI_CFG_PS_LSB +: 2];
      cfg_read_lat <= ctl_reg[`DRI_CTL_RL_LSB +: 3];
      cfg_refresh_rate <= rfc_reg[`DRI_RFC_RATE_LSB +: 16];
      topology <= topo_w;
    end
  end

  dri_init_seq u_seq (
    .core_clk(core_clk),
    .reset(reset),
    .start(start_reg),
    .link_edge(link_edge),
    .mrs_word(mrs_word),
    .emr1_word(emr1_word),
    .cke(mem_cke),
    .cmd(mem_cmd),
    .ba(mem_ba),
    .addr(mem_addr),
    .busy(seq_busy),
    .done(seq_done)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_drain_clear;
    state_reg == ST_DRAIN && !rw_outstanding;
  endsequence
  sequence s_init_begins;
    start_reg ##1 seq_busy && state_reg == ST_INIT;
  endsequence

  a_low_write_init: assert property (
    (trig && state_reg == ST_IDLE) |=> state_reg == ST_DRAIN && cmd_hold)
    else $error("low lane config write did not start reinit");
  a_high_write_quiet: assert property (
    (cfg_wr && wl_reg[1:0] == 2'b00 && state_reg == ST_IDLE && !pend_reg)
    |=> state_reg == ST_IDLE && !cmd_hold)
    else $error("upper lane config write started reinit");
  a_drain_waits: assert property (
    (state_reg == ST_DRAIN && rw_outstanding) |=>
    state_reg == ST_DRAIN && !start_reg && cmd_hold)
    else $error("init began before traffic drained");
  a_drain_then_init: assert property (
    s_drain_clear |=> s_init_begins)
    else $error("drained controller did not begin init");
  a_fifo_kept: assert property (
    (state_reg == ST_DRAIN || (state_reg == ST_INIT && $past(state_reg)
     == ST_DRAIN)) |-> !fifo_flush)
    else $error("register reinit flushed the queues");
  a_timing_locked: assert property (
    (wr_apply && wa_reg == `DRI_OFS_TIM1 && !tim_open) |=>
    $stable(tim1_reg))
    else $error("locked timing register changed");
  a_timing_open: assert property (
    (wr_apply && wa_reg == `DRI_OFS_TIM2 && tim_open && wl_reg == 4'hF)
    |=> tim2_reg == $past(hwdata))
    else $error("unlocked timing register did not take write");
  a_width_decode: assert property (
    (nm_fld == 1'b0) [*2] |-> cfg_bus32)
    else $error("width select zero not a 32-bit bus");
  a_cas_decode: assert property (
    (cl_fld == 3'h4) [*2] |-> cfg_cas_lat == 3'h4)
    else $error("CAS latency not taken directly");
  a_bank_decode: assert property (
    (cfg_reg[`DRI_CFG_IB_LSB +: 2] == 2'h3) [*2] |-> cfg_banks == 4'h8)
    else $error("bank count 3h not eight banks");
  a_page_decode: assert property (
    (cfg_reg[`DRI_CFG_PS_LSB +: 2] == 2'h2) [*2] |->
    cfg_page_words == 12'h400)
    else $error("page size 2h not 1024 words");
  a_mode_word: assert property (
    ($changed(mem_addr) && mem_cmd == DRI_LOAD_MODE && mem_ba == `DRI_BA_MR)
    |-> mem_addr[6:4] == $past(cl_fld) && mem_addr[2:0] == `DRI_MR_BL8 &&
    mem_addr[11:9] == $past(tim1_reg[`DRI_TIM1_WR_LSB +: 3]))
    else $error("mode register word wrong");
endmodule

/* File: dri_mem_model.sv */
// Memory-side model: free-running memory clock and a log of commands
`timescale 1ns/10ps
module dri_mem_model import dri_pkg::*; (
  output logic mem_clk,
  input logic cke,
  input dri_cmd_t cmd,
  input logic [2:0] ba,
  input logic [12:0] addr
);
  dri_cmd_t q_cmd[$];
  logic [2:0] q_ba[$];
  logic [12:0] q_addr[$];
  // Odd start offset keeps this clock unrelated in phase to the core clock
  initial begin
    mem_clk = 1'b0;
    #37;
    forever #100 mem_clk = ~mem_clk;
  end
  // Sample late in each period, past the controller's synchroniser delay
  always begin
    @(posedge mem_clk);
    #150;
    if (cke === 1'b1 && cmd !== DRI_NOP) begin
      q_cmd.push_back(cmd);
      q_ba.push_back(ba);
      q_addr.push_back(addr);
    end
  end
endmodule

/* File: tb_ddr2_reinit_and_config.sv */
// Self-checking bench for the DDR2 reinit and configuration block
`timescale 1ns/10ps
`include "dri_map.svh"
module tb_ddr2_reinit_and_config import dri_pkg::*; ;
  typedef struct packed {
    logic wr;
    logic [7:0] ofs;
    logic [31:0] dat;
  } dri_row_t;
  localparam logic [31:0] cfg_a = {24'h0, `DRI_OFS_CFG};
  localparam logic [31:0] ctl_a = {24'h0, `DRI_OFS_CTL};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic rw_outstanding = 1'b0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, mem_clk_in, cmd_hold, fifo_flush, mem_cke;
  logic cfg_bus32;
  dri_cmd_t mem_cmd;
  logic [2:0] mem_ba, cfg_cas_lat, cfg_read_lat;
  logic [12:0] mem_addr;
  logic [3:0] cfg_banks;
  logic [11:0] cfg_page_words;
  logic [15:0] cfg_refresh_rate;
  dri_topo_t topology;
  dri_row_t rows [19];
  dri_topo_t tp [4];
  int n_mismatch = 0;
  int checked = 0;
  int base;

  always #12.5 core_clk = ~core_clk;

  dri_ctrl DUT (.core_clk(core_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mem_clk_in(mem_clk_in),
    .rw_outstanding(rw_outstanding), .cmd_hold(cmd_hold),
    .fifo_flush(fifo_flush), .mem_cke(mem_cke), .mem_cmd(mem_cmd),
    .mem_ba(mem_ba), .mem_addr(mem_addr), .cfg_bus32(cfg_bus32),
    .cfg_cas_lat(cfg_cas_lat), .cfg_banks(cfg_banks),
    .cfg_page_words(cfg_page_words), .cfg_read_lat(cfg_read_lat),
    .cfg_refresh_rate(cfg_refresh_rate), .topology(topology));

  dri_mem_model u_mem (.mem_clk(mem_clk_in), .cke(mem_cke), .cmd(mem_cmd),
    .ba(mem_ba), .addr(mem_addr));

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Single word transfer; the wait ends only on hready, never on a count
  task automatic bus(input logic wr, input logic [31:0] a,
      input logic [2:0] sz, input logic [31:0] wd, output logic [31:0] r);
    haddr <= a;
    hwrite <= wr;
    hsize <= sz;
    htrans <= 2'h2;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    repeat (2) @(posedge core_clk);
    while (cmd_hold !== 1'b0 && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    chk("init done", 32'(k < 3000), 32'h1);
  endtask

  // Compares the last seven logged commands; base below 0 skips the count
  task automatic chk_init(input int b, input logic drv,
      input logic [2:0] twr, input logic [2:0] cl);
    dri_cmd_t ec [7];
    logic [2:0] eb [7];
    logic [12:0] ea [7];
    int n;
    ec = '{DRI_PRE_ALL, DRI_LOAD_MODE, DRI_LOAD_MODE, DRI_LOAD_MODE,
      DRI_LOAD_MODE, DRI_PRE_ALL, DRI_REFRESH};
    eb = '{3'h0, `DRI_BA_EMR2, `DRI_BA_EMR3, `DRI_BA_EMR1, `DRI_BA_MR,
      3'h0, 3'h0};
    ea = '{`DRI_A10_PRE, 13'h0, 13'h0, `DRI_EMR1_RTT | {11'h0, drv, 1'b0},
      {1'b0, twr, 2'b00, cl, 1'b0, `DRI_MR_BL8}, `DRI_A10_PRE, `DRI_A10_PRE};
    n = u_mem.q_cmd.size();
    if (b >= 0) chk("init count", 32'(n - b), 32'h7);
    if (n >= 7) begin
      for (int i = 0; i < 7; i++) begin
        chk("init cmd", 32'({u_mem.q_cmd[n-7+i], u_mem.q_addr[n-7+i]}),
          32'({ec[i], ea[i]}));
        if (ec[i] == DRI_LOAD_MODE) chk("init bank", 32'(u_mem.q_ba[n-7+i]),
          32'(eb[i]));
      end
    end else begin
      chk("init log", 32'(n), 32'h7);
    end
  endtask

  initial begin
    #1500000;
    n_mismatch++;
    wrap_up;
  end

  initial begin
    rows = '{
      '{1'b1, `DRI_OFS_CFG, 32'h0080_0832},
      '{1'b1, `DRI_OFS_CFG, 32'h0004_0832},
      '{1'b0, `DRI_OFS_CFG, 32'h0004_0832},
      '{1'b1, `DRI_OFS_CFG, 32'h0004_8A32},
      '{1'b1, `DRI_OFS_TIM1, 32'h0005_0000},
      '{1'b1, `DRI_OFS_TIM2, 32'h0000_1234},
      '{1'b1, `DRI_OFS_RFC, 32'h0000_0400},
      '{1'b0, `DRI_OFS_TIM1, 32'h0005_0000},
      '{1'b0, `DRI_OFS_TIM2, 32'h0000_1234},
      '{1'b0, `DRI_OFS_RFC, 32'h0000_0400},
      '{1'b1, `DRI_OFS_CFG, 32'h0004_0A32},
      '{1'b1, `DRI_OFS_TIM1, 32'h0007_0000},
      '{1'b1, `DRI_OFS_TIM2, 32'h0000_5678},
      '{1'b0, `DRI_OFS_TIM1, 32'h0005_0000},
      '{1'b0, `DRI_OFS_TIM2, 32'h0000_1234},
      '{1'b1, `DRI_OFS_CTL, 32'h0000_0006},
      '{1'b0, `DRI_OFS_CTL, 32'h0000_0006},
      '{1'b1, 8'h1C, 32'hFFFF_FFFF},
      '{1'b0, 8'h1C, 32'h0000_0000}};
    tp = '{TOPO_32_X16, TOPO_16_X16, TOPO_16_X8, TOPO_BAD};
    repeat (4) @(posedge core_clk);
    chk("flush in reset", 32'(fifo_flush), 32'h1);
    chk("cke in reset", 32'(mem_cke), 32'h0);
    @(posedge core_clk);
    reset <= 1'b0;
    wait_idle;
    chk_init(0, 1'b0, 3'h3, 3'h4);
    chk("page words", 32'(cfg_page_words), 32'd1024);
    chk("banks", 32'(cfg_banks), 32'h8);
    chk("cas", 32'(cfg_cas_lat), 32'h4);
    chk("wide bus", 32'(cfg_bus32), 32'h1);
    chk("flush after", 32'(fifo_flush), 32'h0);
    for (int i = 0; i < 19; i++) begin
      bus(rows[i].wr, {24'h0, rows[i].ofs}, 3'h2, rows[i].dat, rd);
      chk("okay resp", 32'(hresp), 32'h0);
      if (!rows[i].wr) chk("reg read", rd, rows[i].dat);
    end
    bus(1'b1, cfg_a, 3'h2, 32'h0000_0A32, rd);
    bus(1'b0, cfg_a, 3'h2, 32'h0, rd);
    chk("drive kept", rd, 32'h0004_0A32);
    wait_idle;
    chk("cas", 32'(cfg_cas_lat), 32'h5);
    chk("read lat", 32'(cfg_read_lat), 32'h6);
    chk("refresh", 32'(cfg_refresh_rate), 32'h400);
    chk_init(-1, 1'b1, 3'h5, 3'h5);
    // Accepted traffic still pending: the init must wait for it
    base = u_mem.q_cmd.size();
    rw_outstanding <= 1'b1;
    bus(1'b1, cfg_a, 3'h2, 32'h0004_0A32, rd);
    repeat (100) @(posedge core_clk);
    chk("hold in drain", 32'(cmd_hold), 32'h1);
    chk("no flush", 32'(fifo_flush), 32'h0);
    chk("early init", 32'(u_mem.q_cmd.size() - base), 32'h0);
    bus(1'b0, {24'h0, `DRI_OFS_STAT}, 3'h2, 32'h0, rd);
    chk("status drain", rd, 32'h0000_0006);
    rw_outstanding <= 1'b0;
    wait_idle;
    chk_init(base, 1'b1, 3'h5, 3'h5);
    base = u_mem.q_cmd.size();
    bus(1'b1, cfg_a | 32'h2, 3'h1, 32'h0080_0000, rd);
    repeat (100) @(posedge core_clk);
    chk("upper only", 32'(u_mem.q_cmd.size() - base), 32'h0);
    chk("upper hold", 32'(cmd_hold), 32'h0);
    bus(1'b0, cfg_a, 3'h2, 32'h0, rd);
    chk("upper lanes", rd, 32'h0084_0A32);
    bus(1'b1, cfg_a | 32'h1, 3'h0, 32'h0000_0A00, rd);
    wait_idle;
    chk_init(base, 1'b1, 3'h5, 3'h5);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, cfg_a, 3'h2, (i == 1 || i == 2) ? 32'h0004_4A32 :
        32'h0004_0A32, rd);
      bus(1'b1, ctl_a, 3'h2, (i > 1) ? 32'h0000_0106 : 32'h6, rd);
      wait_idle;
      chk("topology", 32'(topology), 32'(tp[i]));
    end
    bus(1'b0, {24'h0, `DRI_OFS_STAT}, 3'h2, 32'h0, rd);
    chk("status idle", rd, 32'h0000_0018);
    // Second reset mid-run: defaults return and init reruns on its own
    base = u_mem.q_cmd.size();
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("flush again", 32'(fifo_flush), 32'h1);
    chk("hold again", 32'(cmd_hold), 32'h1);
    reset <= 1'b0;
    wait_idle;
    chk_init(base, 1'b0, 3'h3, 3'h4);
    bus(1'b0, cfg_a, 3'h2, 32'h0, rd);
    chk("cfg after reset", rd, `DRI_CFG_RST);
    wrap_up;
  end
endmodule
